//--- rtl/serial_rx_pkg.sv
/*
 * shared constants and carrier types for the serial receiver and lane pll
 * control register slice.
 * assumes a byte-wide register port clocked on the configuration clock.
 */
package serial_rx_pkg;

  // ==========================================================================
  // register map
  localparam int          NREG     = 22;
  localparam int          ADDR_W   = 12;
  localparam logic [11:0] STAT_OFS = 12'h281;

  // offsets, reset values and writable-bit masks, index by index
  localparam logic [11:0] REG_OFS [NREG] = '{
    12'h1b5, 12'h1b9, 12'h1bb, 12'h1bc, 12'h1be, 12'h1bf, 12'h1c0, 12'h1c1,
    12'h1c4, 12'h1c5, 12'h200, 12'h201, 12'h203, 12'h206, 12'h230, 12'h232,
    12'h268, 12'h280, 12'h284, 12'h285, 12'h286, 12'h287};
  localparam logic [7:0] REG_RST [NREG] = '{
    8'h83, 8'h34, 8'h0c, 8'h00, 8'h00, 8'h8d, 8'h2e, 8'h24,
    8'h33, 8'h08, 8'h01, 8'h00, 8'h00, 8'h01, 8'h28, 8'h00,
    8'h62, 8'h00, 8'h77, 8'h87, 8'h08, 8'h3f};
  localparam logic [7:0] REG_MASK [NREG] = '{
    8'hff, 8'hff, 8'h1f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'h01, 8'hff, 8'h03, 8'h01, 8'h3e, 8'hff,
    8'hff, 8'h05, 8'hff, 8'hff, 8'hff, 8'hff};

  // ==========================================================================
  // register indices
  localparam int IDX_VAR_TRIM  = 0;
  localparam int IDX_PUMP_ONE  = 1;
  localparam int IDX_OSC_BIAS  = 2;
  localparam int IDX_OSC_CTRL  = 3;
  localparam int IDX_OSC_PWR   = 4;
  localparam int IDX_OSC_CAL   = 5;
  localparam int IDX_LOCK_CNT  = 6;
  localparam int IDX_PUMP_TWO  = 7;
  localparam int IDX_VAR_ONE   = 8;
  localparam int IDX_VAR_TWO   = 9;
  localparam int IDX_MASTER    = 10;
  localparam int IDX_LANE_PD   = 11;
  localparam int IDX_SYNC_PD   = 12;
  localparam int IDX_CDR_RST   = 13;
  localparam int IDX_OP_MODE   = 14;
  localparam int IDX_RX_CFG3   = 15;
  localparam int IDX_EQ_BIAS   = 16;
  localparam int IDX_PLL_CTRL  = 17;
  localparam int IDX_FILT_ONE  = 18;
  localparam int IDX_FILT_TWO  = 19;
  localparam int IDX_FILT_THR  = 20;
  localparam int IDX_LPUMP_ONE = 21;

  // ==========================================================================
  // field positions
  localparam int BIT_MASTER_OFF  = 0;
  localparam int BIT_SYNC_A_OFF  = 1;
  localparam int BIT_SYNC_B_OFF  = 0;
  localparam int BIT_RECOV_RSTN  = 0;
  localparam int BIT_HALF_RATE   = 5;
  localparam int BIT_OVERSAMPLE  = 1;
  localparam int EQ_SEL_HI       = 7;
  localparam int EQ_SEL_LO       = 6;
  localparam int BIT_PLL_ON      = 0;
  localparam int BIT_PLL_RECAL   = 2;
  localparam int BIT_ST_BAND_HI  = 5;
  localparam int BIT_ST_BAND_LO  = 4;
  localparam int BIT_ST_CAL_OK   = 3;
  localparam int BIT_ST_LOCKED   = 0;

  // equalizer power codes
  localparam logic [1:0] EQ_NORMAL    = 2'h0;
  localparam logic [1:0] EQ_LOW_POWER = 2'h1;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } regReq_t;

  typedef struct packed {
    logic bandHigh;
    logic bandLow;
    logic calDone;
    logic locked;
  } pllStat_t;

  typedef struct packed {
    logic [7:0] varactorTrim;
    logic [7:0] pumpOne;
    logic [7:0] oscBias;
    logic [7:0] oscControl;
    logic [7:0] oscPower;
    logic [7:0] oscCalibration;
    logic [7:0] lockCounter;
    logic [7:0] pumpTwo;
    logic [7:0] varactorOne;
    logic [7:0] varactorTwo;
  } convPllCfg_t;

  typedef struct packed {
    logic [7:0] filterOne;
    logic [7:0] filterTwo;
    logic [7:0] filterThree;
    logic [7:0] pumpOne;
  } lanePllCfg_t;

endpackage

//--- rtl/sync_2ff.sv
/*
 * two-flop level synchroniser, width set by parameter.
 * assumes each bit is a slow level; no bus coherence across bits.
 */
`timescale 1ns/10ps
`default_nettype none
module sync_2ff #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] meta_ff;

  // ==========================================================================
  // first stage feeds only the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= '0;
      syncOut <= '0;
    end else begin
      meta_ff <= asyncIn;
      syncOut <= meta_ff;
    end
  end

endmodule
`default_nettype wire

//--- rtl/lane_pll_cal_ctrl.sv
/*
 * lane pll calibration starter and calibration-valid tracker.
 * assumes calDone is already synchronised to clk by the caller.
 */
`timescale 1ns/10ps
`default_nettype none
module lane_pll_cal_ctrl (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic pllOn,
  input  wire logic recal,
  input  wire logic calDone,
  output logic      calStart,
  output logic      calValid
);

  logic pllOnPrev_ff;
  logic recalPrev_ff;
  logic onRise;
  logic recalRise;

  // ==========================================================================
  // edge detection: only 0 to 1 transitions count
  assign onRise    = pllOn & ~pllOnPrev_ff;
  assign recalRise = recal & ~recalPrev_ff & pllOn;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pllOnPrev_ff <= 1'b0;
      recalPrev_ff <= 1'b0;
    end else begin
      pllOnPrev_ff <= pllOn;
      recalPrev_ff <= recal;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      calStart <= 1'b0;
    end else begin
      calStart <= onRise | recalRise;
    end
  end

  // valid after completion; done wins over a fresh start
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      calValid <= 1'b0;
    end else if (!pllOn) begin
      calValid <= 1'b0;
    end else if (calDone) begin
      calValid <= 1'b1;
    end else if (calStart) begin
      calValid <= 1'b0;
    end
  end

  // ==========================================================================
  // checks
  AST_CAL_ON_EDGE: assert property (
    @(posedge clk) disable iff (!nrst)
    (pllOn && !$past(recal) && recal) |=> calStart)
    else $error("recalibrate edge gave no start pulse");
  AST_CAL_NO_STATIC: assert property (
    @(posedge clk) disable iff (!nrst)
    calStart |-> ($past(pllOn)
                  && (!$past(pllOn, 2) || ($past(recal) && !$past(recal, 2)))))
    else $error("start pulse without a rising edge");

endmodule
`default_nettype wire

//--- rtl/serial_rx_pll_control_regs.sv
/*
 * control and status registers for converter pll tuning, serial receiver
 * power-down, clock-data-recovery modes, equalizer power and the lane pll.
 * assumes a byte-wide register port on clk driven by the serial port front
 * end, and analog pll status levels arriving asynchronously.
 */
//
// Contract
// - master bit powers down all receiver analog
// - per-lane bits power down lane front ends
// - bits one, zero power down sync buffers
// - low recovery reset bit holds recovery logic
// - equalizer code 00 normal, 01 low power
// - recalibrate bit rising edge starts calibration
// - enable bit enables and calibrates lane pll
// - status bit three shows calibration valid
// - status bit zero shows pll locked
// - band edge flags; software then recalibrates
// - lane pll loop filter and charge pump codes
`timescale 1ns/10ps
`default_nettype none
module serial_rx_pll_control_regs
  import serial_rx_pkg::*;
#(
  parameter int LANES = 8
) (
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire serial_rx_pkg::regReq_t    regReq,
  output logic                     [7:0] regRdData,
  input  wire serial_rx_pkg::pllStat_t   pllStatAsync,
  output logic                           receiverMasterOff,
  output logic               [LANES-1:0] laneFrontEndOff,
  output logic                           syncBufferAOff,
  output logic                           syncBufferBOff,
  output logic                           recoveryResetN,
  output logic                           halfRateRecoveryEn,
  output logic                           inputOversampleEn,
  output logic                     [1:0] equalizerPowerSel,
  output logic                           lanePllOn,
  output logic                           lanePllCalStart,
  output logic                     [7:0] linkRxConfig,
  output serial_rx_pkg::convPllCfg_t     convPllCfg,
  output serial_rx_pkg::lanePllCfg_t     lanePllCfg
);

  import serial_rx_pkg::*;

  // ==========================================================================
  // storage and decode
  logic [7:0] regFile_ff [NREG];
  logic [NREG-1:0] hit;
  logic       statHit;
  logic [7:0] regRead;
  logic [7:0] statusByte;
  pllStat_t   pllStat;
  logic       calValid;
  logic       calStart;

  // address match per register
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_dec
      assign hit[gi] = (regReq.addr == REG_OFS[gi]);
    end
  endgenerate
  assign statHit = (regReq.addr == STAT_OFS);

  // ==========================================================================
  // write path
  // masks keep read-only bits at zero
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          regFile_ff[gi] <= REG_RST[gi];
        end else if (regReq.wr && hit[gi]) begin
          regFile_ff[gi] <= regReq.wdata & REG_MASK[gi];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // analog status enters through two flops
  sync_2ff #(
    .W (4)
  ) u_stat_sync (
    .clk     (clk),
    .nrst    (nrst),
    .asyncIn (pllStatAsync),
    .syncOut (pllStat)
  );

  // calibration start and valid tracking
  lane_pll_cal_ctrl u_cal (
    .clk      (clk),
    .nrst     (nrst),
    .pllOn    (regFile_ff[IDX_PLL_CTRL][BIT_PLL_ON]),
    .recal    (regFile_ff[IDX_PLL_CTRL][BIT_PLL_RECAL]),
    .calDone  (pllStat.calDone),
    .calStart (calStart),
    .calValid (calValid)
  );

  // ==========================================================================
  // status byte
  // calibration valid bit
  always_comb begin
    statusByte                 = 8'h00;
    statusByte[BIT_ST_BAND_HI] = pllStat.bandHigh & lanePllOn;
    statusByte[BIT_ST_BAND_LO] = pllStat.bandLow & lanePllOn;
    statusByte[BIT_ST_CAL_OK]  = calValid;
    statusByte[BIT_ST_LOCKED]  = pllStat.locked & lanePllOn;
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    regRead = statHit ? statusByte : 8'h00;
    for (int i = 0; i < NREG; i++) begin
      if (hit[i]) begin
        regRead = regFile_ff[i];
      end
    end
  end

  // read data held until the next read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 8'h00;
    end else if (regReq.rd) begin
      regRdData <= regRead;
    end
  end

  // ==========================================================================
  // control outputs, registered so analog sees glitch-free levels
  logic [LANES-1:0] nxt_laneOff;
  logic             masterBit;

  assign masterBit   = regFile_ff[IDX_MASTER][BIT_MASTER_OFF];
  assign nxt_laneOff = regFile_ff[IDX_LANE_PD][LANES-1:0] | {LANES{masterBit}};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      receiverMasterOff  <= 1'b1;
      laneFrontEndOff    <= {LANES{1'b1}};
      syncBufferAOff     <= 1'b0;
      syncBufferBOff     <= 1'b0;
      recoveryResetN     <= 1'b0;
      halfRateRecoveryEn <= 1'b1;
      inputOversampleEn  <= 1'b0;
      equalizerPowerSel  <= EQ_LOW_POWER;
      lanePllOn          <= 1'b0;
    end else begin
      receiverMasterOff  <= masterBit;
      laneFrontEndOff    <= nxt_laneOff;
      syncBufferAOff     <= regFile_ff[IDX_SYNC_PD][BIT_SYNC_A_OFF];
      syncBufferBOff     <= regFile_ff[IDX_SYNC_PD][BIT_SYNC_B_OFF];
      recoveryResetN     <= regFile_ff[IDX_CDR_RST][BIT_RECOV_RSTN];
      halfRateRecoveryEn <= regFile_ff[IDX_OP_MODE][BIT_HALF_RATE];
      inputOversampleEn  <= regFile_ff[IDX_OP_MODE][BIT_OVERSAMPLE];
      equalizerPowerSel  <= regFile_ff[IDX_EQ_BIAS][EQ_SEL_HI:EQ_SEL_LO];
      lanePllOn          <= regFile_ff[IDX_PLL_CTRL][BIT_PLL_ON];
    end
  end

  assign lanePllCalStart = calStart;

  // ==========================================================================
  // tuning values straight from their registers
  assign linkRxConfig = regFile_ff[IDX_RX_CFG3];
  assign convPllCfg   = '{
    varactorTrim:   regFile_ff[IDX_VAR_TRIM],
    pumpOne:        regFile_ff[IDX_PUMP_ONE],
    oscBias:        regFile_ff[IDX_OSC_BIAS],
    oscControl:     regFile_ff[IDX_OSC_CTRL],
    oscPower:       regFile_ff[IDX_OSC_PWR],
    oscCalibration: regFile_ff[IDX_OSC_CAL],
    lockCounter:    regFile_ff[IDX_LOCK_CNT],
    pumpTwo:        regFile_ff[IDX_PUMP_TWO],
    varactorOne:    regFile_ff[IDX_VAR_ONE],
    varactorTwo:    regFile_ff[IDX_VAR_TWO]};
  assign lanePllCfg   = '{
    filterOne:   regFile_ff[IDX_FILT_ONE],
    filterTwo:   regFile_ff[IDX_FILT_TWO],
    filterThree: regFile_ff[IDX_FILT_THR],
    pumpOne:     regFile_ff[IDX_LPUMP_ONE]};

  // ==========================================================================
  // checks
  AST_MASTER_ALL_OFF: assert property (
    @(posedge clk) disable iff (!nrst)
    masterBit |=> (receiverMasterOff && (&laneFrontEndOff)))
    else $error("master powerdown did not reach all lanes");
  AST_LANE_OFF: assert property (
    @(posedge clk) disable iff (!nrst)
    ##1 laneFrontEndOff == ($past(regFile_ff[IDX_LANE_PD][LANES-1:0])
                            | {LANES{$past(masterBit)}}))
    else $error("lane powerdown does not follow its bits");
  AST_SYNC_BUF: assert property (
    @(posedge clk) disable iff (!nrst)
    (regReq.wr && hit[IDX_SYNC_PD]) |=> ##1
    (syncBufferAOff == $past(regReq.wdata[1], 2)
     && syncBufferBOff == $past(regReq.wdata[0], 2)))
    else $error("sync buffer powerdown wrong after write");
  AST_RECOV_RESET: assert property (
    @(posedge clk) disable iff (!nrst)
    (regReq.wr && hit[IDX_CDR_RST] && !regReq.wdata[0]) |=> ##1
    !recoveryResetN)
    else $error("recovery reset not asserted after clearing bit");
  AST_EQ_SEL: assert property (
    @(posedge clk) disable iff (!nrst)
    (regReq.wr && hit[IDX_EQ_BIAS]) |=> ##1
    equalizerPowerSel == $past(regReq.wdata[7:6], 2))
    else $error("equalizer power code not applied");
  AST_PLL_ON: assert property (
    @(posedge clk) disable iff (!nrst)
    $rose(regFile_ff[IDX_PLL_CTRL][BIT_PLL_ON]) |=> (lanePllOn && calStart))
    else $error("pll enable did not enable and calibrate");
  AST_LOCK_READ: assert property (
    @(posedge clk) disable iff (!nrst)
    (regReq.rd && statHit && lanePllOn) |=>
    regRdData[BIT_ST_LOCKED] == $past(pllStat.locked))
    else $error("lock bit read wrong");
  AST_RO_ZERO: assert property (
    @(posedge clk) disable iff (!nrst)
    (regReq.rd && hit[IDX_PLL_CTRL]) |=> regRdData[7:3] == 5'h00
    && regRdData[1] == 1'b0)
    else $error("reserved control bits read nonzero");
  AST_CAL_VALID: assert property (
    @(posedge clk) disable iff (!nrst)
    (lanePllOn && regFile_ff[IDX_PLL_CTRL][BIT_PLL_ON] && pllStat.calDone)
    |=> calValid)
    else $error("calibration valid not set after completion");
  AST_RECOV_RUN: assert property (
    @(posedge clk) disable iff (!nrst)
    (regReq.wr && hit[IDX_CDR_RST] && regReq.wdata[0]) |=> ##1
    recoveryResetN)
    else $error("recovery reset not released after setting bit");
  AST_MODE_BITS: assert property (
    @(posedge clk) disable iff (!nrst)
    (regReq.wr && hit[IDX_OP_MODE]) |=> ##1
    (halfRateRecoveryEn == $past(regReq.wdata[5], 2)
     && inputOversampleEn == $past(regReq.wdata[1], 2)))
    else $error("recovery mode bits not applied");
  AST_CAL_PULSE: assert property (
    @(posedge clk) disable iff (!nrst)
    lanePllCalStart |=> !lanePllCalStart)
    else $error("calibration start wider than one cycle");

  // ==========================================================================
  // read-side checks; every answer lands one edge after its strobe
  AST_CAL_READ: assert property (
    @(posedge clk) disable iff (!nrst)
    (regReq.rd && statHit) |=> regRdData[3] == $past(calValid))
    else $error("calibration valid bit read wrong");
  AST_STAT_IDLE: assert property (
    @(posedge clk) disable iff (!nrst)
    (regReq.rd && statHit && !lanePllOn) |=>
    (regRdData[5:4] == 2'h0 && regRdData[0] == 1'b0))
    else $error("pll flags read set while pll off");
  AST_BAND_READ: assert property (
    @(posedge clk) disable iff (!nrst)
    (regReq.rd && statHit && lanePllOn) |=>
    regRdData[5:4] == $past({pllStat.bandHigh, pllStat.bandLow}))
    else $error("band edge flags read wrong");
  AST_STAT_RSVD: assert property (
    @(posedge clk) disable iff (!nrst)
    (regReq.rd && statHit) |=>
    (regRdData[7:6] == 2'h0 && regRdData[2:1] == 2'h0))
    else $error("reserved status bits read nonzero");
  AST_UNMAPPED: assert property (
    @(posedge clk) disable iff (!nrst)
    (regReq.rd && !statHit && !(|hit)) |=> regRdData == 8'h00)
    else $error("unmapped offset read nonzero");
  // read data must stand between reads so slow software can fetch it
  AST_RD_HOLD: assert property (
    @(posedge clk) disable iff (!nrst)
    !regReq.rd |=> $stable(regRdData))
    else $error("read data changed without a read");

endmodule
`default_nettype wire

//--- dv/serial_rx_pll_control_regs_tb.sv
/*
 * self-checking bench for the receiver and lane pll control register slice.
 * assumes the byte-wide parallel register port on clk plus the analog pll status inputs.
 */
`timescale 1ns/10ps
`default_nettype none
module serial_rx_pll_control_regs_tb;
  import serial_rx_pkg::*;

  // ==========================================================================
  // clock, reset and stimulus signals
  logic        clk;
  logic        nrst;
  regReq_t     regReq;
  pllStat_t    pllStatAsync;
  logic [7:0]  regRdData;
  logic        receiverMasterOff;
  logic [7:0]  laneFrontEndOff;
  logic        syncBufferAOff;
  logic        syncBufferBOff;
  logic        recoveryResetN;
  logic        halfRateRecoveryEn;
  logic        inputOversampleEn;
  logic [1:0]  equalizerPowerSel;
  logic        lanePllOn;
  logic        lanePllCalStart;
  logic [7:0]  linkRxConfig;
  convPllCfg_t convPllCfg;
  lanePllCfg_t lanePllCfg;
  int          n_errors;
  int          checks_done;
  int          calCount;
  logic [7:0]  rv;

  serial_rx_pll_control_regs #(.LANES(8)) serial_rx_pll_control_regs_inst (
    .clk                (clk),
    .nrst               (nrst),
    .regReq             (regReq),
    .regRdData          (regRdData),
    .pllStatAsync       (pllStatAsync),
    .receiverMasterOff  (receiverMasterOff),
    .laneFrontEndOff    (laneFrontEndOff),
    .syncBufferAOff     (syncBufferAOff),
    .syncBufferBOff     (syncBufferBOff),
    .recoveryResetN     (recoveryResetN),
    .halfRateRecoveryEn (halfRateRecoveryEn),
    .inputOversampleEn  (inputOversampleEn),
    .equalizerPowerSel  (equalizerPowerSel),
    .lanePllOn          (lanePllOn),
    .lanePllCalStart    (lanePllCalStart),
    .linkRxConfig       (linkRxConfig),
    .convPllCfg         (convPllCfg),
    .lanePllCfg         (lanePllCfg)
  );

  // 125 MHz configuration clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // calibration start pulses, counted at falling edges where they are settled
  always @(negedge clk) begin
    if (lanePllCalStart === 1'b1) calCount++;
  end

  // ==========================================================================
  // access and compare tasks
  task automatic chk(input string name, input logic [79:0] seen,
                     input logic [79:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one write strobe, launched and dropped on falling edges
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    regReq = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge clk);
    regReq.wr = 1'b0;
  endtask

  // read data lands at the edge that takes the strobe
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(negedge clk);
    regReq = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge clk);
    regReq.rd = 1'b0;
    d = regRdData;
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // watchdog; the whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_sim;
  end

  // ==========================================================================
  // scenarios
  logic [7:0] calSeq [8] = '{8'h01, 8'h05, 8'h05, 8'h01, 8'h05, 8'h00,
                             8'h04, 8'h05};
  int         calExp [8] = '{1, 1, 0, 0, 1, 0, 0, 1};

  initial begin
    n_errors = 0;
    checks_done = 0;
    calCount = 0;
    nrst = 1'b0;
    regReq = '0;
    pllStatAsync = '0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    settle(1);
    // reset levels at the control outputs
    chk("masterOff", receiverMasterOff, 1'b1);
    chk("laneOff", laneFrontEndOff, 8'hff);
    chk("syncA", syncBufferAOff, 1'b0);
    chk("syncB", syncBufferBOff, 1'b0);
    chk("recovRstN", recoveryResetN, 1'b1);
    chk("halfRate", halfRateRecoveryEn, 1'b1);
    chk("eqSel", equalizerPowerSel, EQ_LOW_POWER);
    chk("overRst", inputOversampleEn, 1'b0);
    chk("laneCfgRst", lanePllCfg, 32'h7787083f);
    chk("pllOn", lanePllOn, 1'b0);
    // reset values of every mapped register
    for (int i = 0; i < NREG; i++) begin
      rd(REG_OFS[i], rv);
      chk("resetVal", rv, REG_RST[i]);
    end
    // read-only bits stay zero under all-ones and all-zeros writes
    for (int i = 0; i < NREG; i++) begin
      wr(REG_OFS[i], 8'hff);
      rd(REG_OFS[i], rv);
      chk("maskOnes", rv, REG_MASK[i]);
      wr(REG_OFS[i], 8'h00);
      rd(REG_OFS[i], rv);
      chk("maskZeros", rv, 8'h00);
    end
    // status writes and unmapped places are ignored
    wr(STAT_OFS, 8'hff);
    rd(STAT_OFS, rv);
    chk("statusWr", rv, 8'h00);
    wr(12'h202, 8'h5a);
    rd(12'h202, rv);
    chk("unmapped", rv, 8'h00);
    // master clear lets per-lane bits through; master set forces all off
    wr(12'h201, 8'ha5);
    settle(2);
    chk("laneOffA5", laneFrontEndOff, 8'ha5);
    chk("masterLow", receiverMasterOff, 1'b0);
    wr(12'h200, 8'h01);
    settle(2);
    chk("laneOffAll", laneFrontEndOff, 8'hff);
    chk("masterHigh", receiverMasterOff, 1'b1);
    // sync buffers, each bit on its own
    wr(12'h203, 8'h02);
    settle(2);
    chk("syncAonly", {syncBufferAOff, syncBufferBOff}, 2'b10);
    wr(12'h203, 8'h01);
    settle(2);
    chk("syncBonly", {syncBufferAOff, syncBufferBOff}, 2'b01);
    // recovery reset: zero holds, one releases
    chk("recovHeld", recoveryResetN, 1'b0);
    wr(12'h206, 8'h01);
    settle(2);
    chk("recovRun", recoveryResetN, 1'b1);
    // low-rate then high-rate mode, reserved field kept at its default
    wr(12'h230, 8'h0a);
    settle(2);
    chk("overLow", {halfRateRecoveryEn, inputOversampleEn}, 2'b01);
    wr(12'h230, 8'h28);
    settle(2);
    chk("halfHigh", {halfRateRecoveryEn, inputOversampleEn}, 2'b10);
    // equalizer codes, reserved field rewritten with 0x22
    wr(12'h268, 8'h22);
    settle(2);
    chk("eqNormal", equalizerPowerSel, EQ_NORMAL);
    wr(12'h268, 8'h62);
    settle(2);
    chk("eqLow", equalizerPowerSel, EQ_LOW_POWER);
    // setup values reach the analog configuration outputs
    wr(12'h232, 8'hff);
    wr(12'h1b9, 8'h24);
    wr(12'h1bc, 8'h0d);
    wr(12'h1be, 8'h02);
    wr(12'h1bf, 8'h8e);
    wr(12'h1c0, 8'h2a);
    wr(12'h1c1, 8'h2a);
    wr(12'h1c4, 8'h7e);
    wr(12'h284, 8'h62);
    wr(12'h285, 8'hc9);
    wr(12'h286, 8'h0e);
    wr(12'h287, 8'h12);
    settle(2);
    chk("linkCfg", linkRxConfig, 8'hff);
    chk("convCfg", {convPllCfg.pumpOne, convPllCfg.oscControl,
        convPllCfg.oscPower}, 24'h240d02);
    chk("convSetup", {convPllCfg.oscCalibration, convPllCfg.lockCounter,
        convPllCfg.pumpTwo, convPllCfg.varactorOne}, 32'h8e2a2a7e);
    chk("laneCfg", lanePllCfg, 32'h62c90e12);
    // oscillator fields picked per frequency, reserved nibble kept at 8
    wr(12'h1b5, 8'h85);
    wr(12'h1bb, 8'h13);
    wr(12'h1c5, 8'h0b);
    settle(1);
    chk("oscFields", {convPllCfg.varactorTrim, convPllCfg.oscBias,
        convPllCfg.varactorTwo}, 24'h85130b);
    // enable and recalibrate edges; static levels and pll-off give nothing
    for (int i = 0; i < 8; i++) begin
      calCount = 0;
      wr(12'h280, calSeq[i]);
      settle(3);
      chk("calPulses", calCount, calExp[i]);
      chk("pllOnLvl", lanePllOn, calSeq[i][0]);
    end
    // live status while enabled, cleared once disabled
    pllStatAsync = '{bandHigh: 1'b1, bandLow: 1'b1, calDone: 1'b1,
                     locked: 1'b1};
    settle(6);
    rd(STAT_OFS, rv);
    chk("statusOn", rv, 8'h39);
    pllStatAsync.bandLow = 1'b0;
    settle(6);
    rd(STAT_OFS, rv);
    chk("bandOnly", rv[5:4], 2'b10);
    chk("lockBit", rv[0], 1'b1);
    wr(12'h280, 8'h00);
    settle(6);
    rd(STAT_OFS, rv);
    chk("statusOff", rv, 8'h00);
    pllStatAsync = '0;
    settle(2);
    // mid-run reset returns controls and registers to their defaults
    nrst = 1'b0;
    settle(2);
    nrst = 1'b1;
    settle(1);
    chk("rstMaster", {receiverMasterOff, laneFrontEndOff}, 9'h1ff);
    chk("rstSync", {syncBufferAOff, syncBufferBOff}, 2'b00);
    chk("rstRecov", recoveryResetN, 1'b1);
    chk("rstLaneCfg", lanePllCfg, 32'h7787083f);
    rd(12'h1b5, rv);
    chk("rstTrim", rv, 8'h83);
    end_sim;
  end

endmodule
`default_nettype wire
